// >>> design/vrts_defines.svh
// Timing counts and serial-counter constants for the video DRAM host
`ifndef VRTS_DEFINES_SVH
`define VRTS_DEFINES_SVH

`define VRTS_CLK_NS 10
// Least times round up to whole cycles
`define VRTS_CYC(ns) (((ns) + `VRTS_CLK_NS - 1) / `VRTS_CLK_NS)

// Address and control setup before the row strobe falls
`define VRTS_T_ASU_NS 10
// Control and row address hold after the row strobe falls
`define VRTS_T_RAH_NS 15
// Column strobe low before the transfer gate rises
`define VRTS_T_CAS_NS 35
// Transfer gate high to row strobe high
`define VRTS_T_TRD_NS 20
// Row strobe precharge
`define VRTS_T_RP_NS 80

`define VRTS_N_ASU `VRTS_CYC(`VRTS_T_ASU_NS)
`define VRTS_N_RAH `VRTS_CYC(`VRTS_T_RAH_NS)
`define VRTS_N_CAS `VRTS_CYC(`VRTS_T_CAS_NS)
`define VRTS_N_TRD `VRTS_CYC(`VRTS_T_TRD_NS)
`define VRTS_N_RP `VRTS_CYC(`VRTS_T_RP_NS)

`define VRTS_POS_LO_END 8'h7f
`define VRTS_POS_HI_END 8'hff
`define VRTS_SINCE_MIN 2'h2
`define VRTS_FIFO_MARGIN 3

`endif

// >>> design/vrts_fifo.sv
// Serial read-data FIFO with a registered output stage
`timescale 1ns/100ps
module vrts_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_wr_valid,
  input wire logic [W-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level,
  // Drain side
  output logic o_rd_valid,
  output logic [W-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [W-1:0] out_q;
  logic ov_q;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("vrts_fifo: depth must be a power of two");
  end

  wire do_wr = i_wr_valid && o_wr_ready;
  wire do_ld = (!ov_q || i_rd_ready) && cnt_q != '0;
  wire [CW-1:0] cnt_d = cnt_q + CW'(do_wr) - CW'(do_ld);

  assign o_wr_ready = cnt_q < CW'(DEPTH);
  assign o_level = cnt_q;
  assign o_rd_valid = ov_q;
  assign o_rd_data = out_q;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem_q[wp_q] <= i_wr_data;
    end
    if (do_ld) begin
      out_q <= mem_q[rp_q];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(do_wr);
      rp_q <= rp_q + AW'(do_ld);
      cnt_q <= cnt_d;
      ov_q <= do_ld || (ov_q && !i_rd_ready);
    end
  end
endmodule

// >>> design/vrts_host.sv
// Host that runs transfer cycles and the serial port of a video DRAM
//
// Function
// - Writes may mix into page reads; select level set at both strobe falls.
// - Late write in page mode needs transfer gate high throughout.
// - Early write: transfer gate is free after its hold time past row fall.
// - With persistent lane mask, lane mask select stays high during refresh.
// - Pseudo-transfer needs shift port gate high at row strobe fall.
// - Gate low, mask low: register-to-memory, alternate write or pseudo.
// - Gate low, mask high: memory-to-register, or split when select high.
// - After read transfer, first word appears on a shift clock rise.
// - Two shift clocks between split reloads, and read then split.
// - Do a normal read transfer before the first split transfer.
// - Split into inactive half may precede the 127 or 255 boundary.
// - Enter write mode by a transfer write before shifting data in.
// - Keep transfer gate high at row fall when no transfer is wanted.
// - Reading needs a prior transfer read; a transfer write blocks it.
`timescale 1ns/100ps
`include "vrts_defines.svh"
module vrts_host #(
  parameter int SC_HALF = 2,
  parameter int DW = 8,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Command port
  input wire logic i_cmd_valid,
  input wire vrts_pkg::vrts_cmd_type i_cmd,
  input wire logic [8:0] i_cmd_row,
  input wire logic [7:0] i_cmd_col,
  output logic o_cmd_ready,
  output logic o_cmd_err,
  // Serial stream
  input wire logic i_serial_en,
  input wire logic i_wr_valid,
  input wire logic [DW-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [DW-1:0] o_rd_data,
  input wire logic i_rd_ready,
  // Status
  output logic o_write_mode,
  output logic o_read_mode,
  output logic [7:0] o_serial_pos,
  output logic o_half_active,
  // Device pins
  output logic o_ras_n,
  output logic o_cas_n,
  output logic [8:0] o_addr,
  output logic o_transfer_gate_n,
  output logic o_we_n,
  output logic o_special_function_select,
  output logic o_shift_port_gate_n,
  output logic o_shift_clock,
  input wire logic [DW-1:0] i_shift_data_pins,
  output logic [DW-1:0] o_shift_data_pins,
  output logic o_shift_data_pins_oe_n,
  input wire logic i_half_activity_flag
);
  localparam int PW = $clog2(FIFO_DEPTH+1);

  if (SC_HALF < 2 || SC_HALF > 256 || FIFO_DEPTH < 4) begin : g_chk
    $error("vrts_host: unsupported parameter");
  end

  vrts_pkg::vrts_state_type state_q, state_d;
  vrts_pkg::vrts_cmd_type cmd_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] col_q;
  logic [8:0] addr_q, addr_d;
  logic ras_q, ras_d;
  logic cas_q, cas_d;
  logic trg_q, trg_d;
  logic we_q, we_d;
  logic dsf_q, dsf_d;
  logic se_q, se_d;
  logic wmode_q;
  logic rmode_q;
  logic init_q;
  logic [1:0] since_q;
  logic [7:0] pos_q;
  logic [7:0] tap_q;
  logic pend_q;
  logic sc_q;
  logic [7:0] hc_q;
  logic loaded_q;
  logic [DW-1:0] sdq_q;
  logic oe_n_q;
  logic [1:0] cap_q;
  logic primed_q;
  logic err_q;
  logic [DW:0] sync_q;
  logic [PW-1:0] fifo_level;
  logic fifo_wr_ready;

  // Command decode at the port
  wire c_split = i_cmd == vrts_pkg::CMD_SPLIT_XFER;
  wire c_rd = i_cmd == vrts_pkg::CMD_READ_XFER || c_split;
  wire c_cbr = i_cmd == vrts_pkg::CMD_REFRESH_CBR;
  wire c_ref = i_cmd == vrts_pkg::CMD_REFRESH_RAS || c_cbr;
  wire c_alt = i_cmd == vrts_pkg::CMD_ALT_WRITE;
  wire c_sin = i_cmd == vrts_pkg::CMD_WRITE_XFER;
  wire c_ok = i_cmd inside {vrts_pkg::CMD_READ_XFER,
    vrts_pkg::CMD_SPLIT_XFER, vrts_pkg::CMD_WRITE_XFER,
    vrts_pkg::CMD_ALT_WRITE, vrts_pkg::CMD_PSEUDO,
    vrts_pkg::CMD_REFRESH_RAS, vrts_pkg::CMD_REFRESH_CBR};
  // Split refused before a normal read or too soon after a reload
  wire c_bad = !c_ok ||
    (c_split && (!init_q || since_q < `VRTS_SINCE_MIN));
  wire cmd_go = i_cmd_valid && o_cmd_ready;
  wire start = cmd_go && !c_bad;

  // Decode of the command in flight
  wire q_split = cmd_q == vrts_pkg::CMD_SPLIT_XFER;
  wire q_rd = cmd_q == vrts_pkg::CMD_READ_XFER || q_split;
  wire q_ronly = cmd_q == vrts_pkg::CMD_REFRESH_RAS;
  wire q_ref = q_ronly || cmd_q == vrts_pkg::CMD_REFRESH_CBR;
  wire q_wr = !q_rd && !q_ref;
  wire tdone = cnt_q == 4'h0;
  wire fin = state_q == vrts_pkg::ST_HOLD && tdone;
  wire idle = state_q == vrts_pkg::ST_IDLE;

  // Shift clock divider; the divider always counts, but the clock only rises between transfer cycles
  wire tick = hc_q == 8'h00;
  wire room = fifo_wr_ready &&
    fifo_level <= PW'(FIFO_DEPTH - `VRTS_FIFO_MARGIN);
  wire idle_ok = idle && !i_cmd_valid && i_serial_en;
  wire run = idle_ok && (wmode_q ? loaded_q : rmode_q && room);
  wire rise = tick && !sc_q && run;
  wire fall = tick && sc_q;
  wire load = idle && wmode_q && !sc_q && !loaded_q && i_wr_valid;
  wire at_end = pos_q == `VRTS_POS_LO_END || pos_q == `VRTS_POS_HI_END;
  wire push = cap_q[1];

  assign o_cmd_ready = idle && !sc_q;
  assign o_wr_ready = load;

  always_comb begin
    state_d = state_q;
    cnt_d = tdone ? cnt_q : cnt_q - 4'h1;
    addr_d = addr_q;
    ras_d = ras_q;
    cas_d = cas_q;
    trg_d = trg_q;
    we_d = we_q;
    dsf_d = dsf_q;
    se_d = se_q;
    unique case (state_q)
      vrts_pkg::ST_IDLE: begin
        se_d = !i_serial_en;
        if (start) begin
          state_d = vrts_pkg::ST_SETUP;
          cnt_d = 4'(`VRTS_N_ASU - 1);
          addr_d = i_cmd_row;
          trg_d = c_ref;
          we_d = c_rd || c_ref;
          dsf_d = c_split || c_alt;
          se_d = !c_sin;
          cas_d = !c_cbr;
        end
      end
      vrts_pkg::ST_SETUP: begin
        if (tdone) begin
          state_d = vrts_pkg::ST_RAS;
          cnt_d = 4'(`VRTS_N_RAH - 1);
          ras_d = 1'b0;
        end
      end
      vrts_pkg::ST_RAS: begin
        if (tdone) begin
          state_d = vrts_pkg::ST_CAS;
          cnt_d = 4'(`VRTS_N_CAS - 1);
          addr_d = {1'b0, col_q};
          cas_d = q_ronly;
          // Write transfers no longer need the gate once it was held
          if (!q_rd) begin
            trg_d = 1'b1;
          end
        end
      end
      vrts_pkg::ST_CAS: begin
        if (tdone) begin
          state_d = vrts_pkg::ST_HOLD;
          cnt_d = 4'(`VRTS_N_TRD - 1);
          trg_d = 1'b1;
        end
      end
      vrts_pkg::ST_HOLD: begin
        if (tdone) begin
          state_d = vrts_pkg::ST_PRE;
          cnt_d = 4'(`VRTS_N_RP - 1);
          ras_d = 1'b1;
          cas_d = 1'b1;
          we_d = 1'b1;
          dsf_d = 1'b0;
          se_d = 1'b1;
        end
      end
      vrts_pkg::ST_PRE: begin
        if (tdone) begin
          state_d = vrts_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = vrts_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin and sequencer registers; gate idles high so page cycles are safe
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= vrts_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      addr_q <= 9'h000;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      trg_q <= 1'b1;
      we_q <= 1'b1;
      dsf_q <= 1'b0;
      se_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      ras_q <= ras_d;
      cas_q <= cas_d;
      trg_q <= trg_d;
      we_q <= we_d;
      dsf_q <= dsf_d;
      se_q <= se_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cmd_q <= vrts_pkg::CMD_READ_XFER;
      col_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      err_q <= cmd_go && c_bad;
      if (start) begin
        cmd_q <= i_cmd;
        col_q <= i_cmd_col;
      end
    end
  end

  // Port mode as the device keeps it
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wmode_q <= 1'b0;
      rmode_q <= 1'b0;
      init_q <= 1'b0;
    end else if (fin && q_rd) begin
      wmode_q <= 1'b0;
      rmode_q <= 1'b1;
      init_q <= init_q || !q_split;
    end else if (fin && q_wr) begin
      wmode_q <= 1'b1;
      rmode_q <= 1'b0;
    end
  end

  // Model of the device's serial address counter
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pos_q <= 8'h00;
      tap_q <= 8'h00;
      pend_q <= 1'b0;
    end else if (fin && q_split) begin
      tap_q <= col_q;
      pend_q <= 1'b1;
    end else if (fin && q_wr) begin
      pos_q <= col_q;
      pend_q <= 1'b0;
    end else if (fin && q_rd) begin
      pos_q <= col_q;
      pend_q <= 1'b0;
    end else if (rise && at_end && pend_q) begin
      pos_q <= tap_q;
      pend_q <= 1'b0;
    end else if (rise) begin
      pos_q <= pos_q + 8'h01;
    end
  end

  // Reload spacing counts shift clock rises, saturating at the minimum
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      since_q <= 2'h0;
    end else if (fin && q_rd) begin
      since_q <= 2'h0;
    end else if (rise && since_q < `VRTS_SINCE_MIN) begin
      since_q <= since_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hc_q <= 8'h00;
      sc_q <= 1'b0;
    end else begin
      hc_q <= tick ? 8'(SC_HALF - 1) : hc_q - 8'h01;
      sc_q <= rise || (sc_q && !fall);
    end
  end

  // Write data changes only while the shift clock is low
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      loaded_q <= 1'b0;
      sdq_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      loaded_q <= !rise && (loaded_q || load) && wmode_q;
      if (load) begin
        sdq_q <= i_wr_data;
      end
      oe_n_q <= !(wmode_q && idle && i_serial_en);
    end
  end

  // The first rise after a read transfer only presents word one; each
  // later rise samples the word of the rise before, two syncs late
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      primed_q <= 1'b0;
      cap_q <= 2'h0;
    end else begin
      if (fin && q_rd && !q_split) begin
        primed_q <= 1'b0;
      end else if (rise && rmode_q) begin
        primed_q <= 1'b1;
      end
      cap_q <= {cap_q[0], rise && primed_q && rmode_q};
    end
  end

  vrts_sync #(.W(DW + 1)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({i_half_activity_flag, i_shift_data_pins}),
    .o_q(sync_q)
  );

  vrts_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_wr_valid(push),
    .i_wr_data(sync_q[DW-1:0]),
    .o_wr_ready(fifo_wr_ready),
    .o_level(fifo_level),
    .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data),
    .i_rd_ready(i_rd_ready)
  );

  assign o_cmd_err = err_q;
  assign o_write_mode = wmode_q;
  assign o_read_mode = rmode_q;
  assign o_serial_pos = pos_q;
  assign o_half_active = sync_q[DW];
  assign o_ras_n = ras_q;
  assign o_cas_n = cas_q;
  assign o_addr = addr_q;
  assign o_transfer_gate_n = trg_q;
  assign o_we_n = we_q;
  assign o_special_function_select = dsf_q;
  assign o_shift_port_gate_n = se_q;
  assign o_shift_clock = sc_q;
  assign o_shift_data_pins = sdq_q;
  assign o_shift_data_pins_oe_n = oe_n_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_pseudo_gate_high: assert property (
    $fell(o_ras_n) && cmd_q == vrts_pkg::CMD_PSEUDO
    |-> o_shift_port_gate_n && !o_transfer_gate_n && !o_we_n)
    else $error("pseudo transfer without shift port gate high");
  a_write_decode: assert property (
    $fell(o_ras_n) && q_wr |-> !o_transfer_gate_n && !o_we_n &&
    o_special_function_select == (cmd_q == vrts_pkg::CMD_ALT_WRITE))
    else $error("transfer write levels wrong at row fall");
  a_read_decode: assert property (
    $fell(o_ras_n) && q_rd |-> !o_transfer_gate_n && o_we_n &&
    o_special_function_select == q_split)
    else $error("transfer read levels wrong at row fall");
  a_refresh_gate: assert property (
    $fell(o_ras_n) && q_ref |-> o_transfer_gate_n)
    else $error("refresh started with transfer gate low");
  a_refresh_mask: assert property (
    $fell(o_ras_n) && q_ref |-> o_we_n throughout (!o_ras_n)[*8])
    else $error("lane mask select dropped in refresh");
  a_split_spacing: assert property (
    $fell(o_ras_n) && q_split |-> $past(since_q, 3) >= `VRTS_SINCE_MIN)
    else $error("split transfer too soon after reload");
  a_split_after_read: assert property (
    $fell(o_ras_n) && q_split |-> init_q)
    else $error("split transfer before a normal read");
  a_gate_hold: assert property (
    $fell(o_ras_n) && !o_transfer_gate_n |-> (!o_transfer_gate_n)[*2])
    else $error("transfer gate released before its hold");
  a_select_both: assert property (
    $fell(o_cas_n) && !q_ref |-> $stable(o_special_function_select)
    ##1 $stable(o_special_function_select))
    else $error("select level moved at column strobe fall");
  a_no_sc_xfer: assert property (
    !idle |-> !$rose(o_shift_clock))
    else $error("shift clock rose during a transfer cycle");
  a_read_mode: assert property (
    push |-> o_read_mode && fifo_wr_ready)
    else $error("serial read outside read mode");
  a_write_mode: assert property (
    $rose(o_shift_clock) && o_write_mode |-> !o_shift_data_pins_oe_n &&
    $stable(o_shift_data_pins))
    else $error("shift data not driven at shift clock rise");

  c_read_xfer: cover property ($fell(o_ras_n) && q_rd && !q_split);
  c_split_xfer: cover property ($fell(o_ras_n) && q_split);
  c_pseudo: cover property (fin && cmd_q == vrts_pkg::CMD_PSEUDO);
  c_fifo_full: cover property (!fifo_wr_ready);
  c_tap_reload: cover property (rise && at_end && pend_q);
endmodule

// >>> design/vrts_pkg.sv
// Types for the video DRAM transfer and serial-port host
package vrts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_RAS = 3'h3,
    ST_CAS = 3'h2,
    ST_HOLD = 3'h6,
    ST_PRE = 3'h7
  } vrts_state_type;

  typedef enum logic [2:0] {
    CMD_READ_XFER = 3'h0,
    CMD_SPLIT_XFER = 3'h1,
    CMD_WRITE_XFER = 3'h2,
    CMD_ALT_WRITE = 3'h3,
    CMD_PSEUDO = 3'h4,
    CMD_REFRESH_RAS = 3'h5,
    CMD_REFRESH_CBR = 3'h6
  } vrts_cmd_type;

endpackage

// >>> design/vrts_sync.sv
// Two-flop synchroniser for pins that come from outside the clock domain
`timescale 1ns/100ps
module vrts_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_chk
    $error("vrts_sync: width must be positive");
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule

// >>> tb/tb_video_ram_transfer_serial_port.sv
// Self-checking bench for the video DRAM transfer and serial-port host
`timescale 1ns/100ps
module tb_video_ram_transfer_serial_port;
  typedef struct packed {
    vrts_pkg::vrts_cmd_type cmd;
    logic [8:0] row;
    logic [7:0] col;
    logic err;
    logic wm;
    logic rm;
  } vrts_row_type;
  localparam vrts_row_type ROWS [10] = '{
    '{vrts_pkg::CMD_SPLIT_XFER, 9'h001, 8'h00, 1'b1, 1'b0, 1'b0},
    '{vrts_pkg::CMD_REFRESH_RAS, 9'h002, 8'h00, 1'b0, 1'b0, 1'b0},
    '{vrts_pkg::CMD_REFRESH_CBR, 9'h000, 8'h00, 1'b0, 1'b0, 1'b0},
    '{vrts_pkg::CMD_READ_XFER, 9'h001, 8'h10, 1'b0, 1'b0, 1'b1},
    '{vrts_pkg::CMD_SPLIT_XFER, 9'h002, 8'h10, 1'b1, 1'b0, 1'b1},
    '{vrts_pkg::CMD_PSEUDO, 9'h000, 8'h20, 1'b0, 1'b1, 1'b0},
    '{vrts_pkg::CMD_ALT_WRITE, 9'h009, 8'h00, 1'b0, 1'b1, 1'b0},
    '{vrts_pkg::CMD_WRITE_XFER, 9'h009, 8'h00, 1'b0, 1'b1, 1'b0},
    '{vrts_pkg::vrts_cmd_type'(3'h7), 9'h000, 8'h00, 1'b1, 1'b1, 1'b0},
    '{vrts_pkg::CMD_READ_XFER, 9'h001, 8'h00, 1'b0, 1'b0, 1'b1}};

  logic clk, rstn, cmd_valid, serial_en, wr_valid, rd_ready;
  vrts_pkg::vrts_cmd_type cmd;
  logic [8:0] cmd_row;
  logic [7:0] cmd_col, wr_data, p;
  int mismatches = 0, comparisons = 0, cycles = 0;
  wire logic cmd_ready, cmd_err, wr_ready, rd_valid, write_mode, read_mode;
  wire logic half_active, ras_n, cas_n, trg_n, we_n, special_function_select, se_n, sc, oe_n;
  wire logic dev_drive, haf, conflict;
  wire logic [7:0] rd_data, serial_pos, host_sdq, dev_sdq, shift_data_pins;
  wire logic [8:0] addr;
  wire vrts_pkg::vrts_cmd_type cycle;

  assign shift_data_pins = !oe_n ? host_sdq : dev_sdq;

  vrts_host #(.SC_HALF(2), .DW(8), .FIFO_DEPTH(16)) vrts_host_i (
    .i_clk(clk), .i_rstn(rstn), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_row(cmd_row), .i_cmd_col(cmd_col), .o_cmd_ready(cmd_ready),
    .o_cmd_err(cmd_err), .i_serial_en(serial_en), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .o_wr_ready(wr_ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_rd_ready(rd_ready), .o_write_mode(write_mode),
    .o_read_mode(read_mode), .o_serial_pos(serial_pos),
    .o_half_active(half_active), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_addr(addr), .o_transfer_gate_n(trg_n), .o_we_n(we_n),
    .o_special_function_select(special_function_select), .o_shift_port_gate_n(se_n),
    .o_shift_clock(sc), .i_shift_data_pins(shift_data_pins), .o_shift_data_pins(host_sdq),
    .o_shift_data_pins_oe_n(oe_n), .i_half_activity_flag(haf));

  vrts_dev_model vrts_dev_model_i (
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_addr(addr),
    .i_transfer_gate_n(trg_n), .i_we_n(we_n),
    .i_special_function_select(special_function_select), .i_shift_port_gate_n(se_n),
    .i_shift_clock(sc), .i_sdq(shift_data_pins), .i_host_oe_n(oe_n), .o_sdq(dev_sdq),
    .o_drive(dev_drive), .o_half_activity_flag(haf), .o_cycle(cycle),
    .o_conflict(conflict));

  function automatic logic [7:0] pat(input int r, input int c);
    return r[7:0] * 8'h03 ^ c[7:0];
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Holds the request until taken, then waits for idle again
  task automatic do_cmd(input vrts_row_type r);
    int n;
    logic err;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= r.cmd;
    cmd_row <= r.row;
    cmd_col <= r.col;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    #1 err = cmd_err;
    @(posedge clk);
    #1 err = err | cmd_err;
    check("cmd_err", err, r.err);
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    check("cmd_ready", n < 100, 1);
  endtask

  task automatic get_word(input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    while (!(rd_valid === 1'b1 && rd_ready === 1'b1) && n < 200) begin
      n++;
      @(posedge clk);
    end
    check("rd_data", rd_data, exp);
  endtask

  task automatic put_word(input logic [7:0] w);
    int n;
    n = 0;
    wr_data <= w;
    @(posedge clk);
    while (wr_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk);
    end
    check("wr_taken", n < 200, 1);
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    rstn = 0;
    cmd_valid = 0;
    cmd = vrts_pkg::CMD_READ_XFER;
    cmd_row = 9'h000;
    cmd_col = 8'h00;
    serial_en = 0;
    wr_valid = 0;
    wr_data = 8'h00;
    rd_ready = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check("reset", {cmd_ready, ras_n, cas_n, trg_n, we_n, se_n, oe_n, special_function_select,
                       write_mode, read_mode, rd_valid, cmd_err, serial_pos},
                      {12'hfe0, 8'h00});
    @(posedge clk);
    foreach (ROWS[i]) begin
      do_cmd(ROWS[i]);
      if (!ROWS[i].err) check("cycle", cycle, ROWS[i].cmd);
      check("modes", {write_mode, read_mode},
            {ROWS[i].wm, ROWS[i].rm});
    end
    // Read stream fills the buffer while the far side stalls
    do_cmd('{vrts_pkg::CMD_READ_XFER, 9'h003, 8'h60, 1'b0, 1'b0, 1'b1});
    serial_en <= 1'b1;
    repeat (300) @(posedge clk);
    p = serial_pos;
    repeat (20) @(posedge clk);
    check("stalled", {rd_valid, serial_pos}, {1'b1, p});
    do_cmd('{vrts_pkg::CMD_SPLIT_XFER, 9'h005, 8'h90,
             1'b0, 1'b0, 1'b1});
    rd_ready <= 1'b1;
    for (int i = 0; i < 40; i++)
      get_word(i < 32 ? pat(3, 'h60 + i) :
               pat(5, 'h90 + i - 32));
    check("half", half_active, 1'b1);
    serial_en <= 1'b0;
    repeat (30) @(posedge clk);
    // Serial input, write back to a row, then read it again
    do_cmd('{vrts_pkg::CMD_PSEUDO, 9'h000, 8'h20, 1'b0, 1'b1, 1'b0});
    serial_en <= 1'b1;
    wr_valid <= 1'b1;
    for (int i = 0; i < 4; i++)
      put_word(8'ha0 + i[7:0]);
    wr_valid <= 1'b0;
    check("sdq_dir", oe_n, 1'b0);
    // A pending command holds the shift clock, so let the last word go in
    repeat (8) @(posedge clk);
    check("wr_pos", serial_pos, 8'h24);
    do_cmd('{vrts_pkg::CMD_WRITE_XFER, 9'h007, 8'h20, 1'b0, 1'b1, 1'b0});
    do_cmd('{vrts_pkg::CMD_READ_XFER, 9'h007, 8'h20, 1'b0, 1'b0, 1'b1});
    for (int i = 0; i < 4; i++)
      get_word(8'ha0 + i[7:0]);
    get_word(pat(3, 'h24));
    check("conflict", conflict, 1'b0);
    give_verdict();
  end
endmodule

// >>> tb/vrts_dev_model.sv
// Behavioural video DRAM: transfer decode, shift register and serial port
`timescale 1ns/100ps
module vrts_dev_model (
  // Strobes and controls
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic [8:0] i_addr,
  input wire logic i_transfer_gate_n,
  input wire logic i_we_n,
  input wire logic i_special_function_select,
  input wire logic i_shift_port_gate_n,
  // Serial port
  input wire logic i_shift_clock,
  input wire logic [7:0] i_sdq,
  input wire logic i_host_oe_n,
  output logic [7:0] o_sdq,
  output logic o_drive,
  output logic o_half_activity_flag,
  // Observation
  output vrts_pkg::vrts_cmd_type o_cycle,
  output logic o_conflict
);
  logic [7:0] mem [0:511][0:255];
  logic [7:0] shift_register_array [0:255];
  logic [8:0] row_q;
  logic [7:0] col_q, tap_q, data_q;
  logic [7:0] pos_q = 8'h00;
  logic rd_q = 0, wr_q = 0, shown_q = 0, split_q = 0, xfer_q = 0;

  initial begin
    for (int r = 0; r < 512; r++)
      for (int c = 0; c < 256; c++)
        mem[r][c] = r[7:0] * 8'h03 ^ c[7:0];
    data_q = 8'h00;
    o_conflict = 0;
    o_cycle = vrts_pkg::CMD_REFRESH_RAS;
  end

  always @(negedge i_ras_n) begin
    row_q = i_addr;
    // Only the serial side is modelled; the random port stays off here
    xfer_q = !i_transfer_gate_n;
    if (i_transfer_gate_n)
      o_cycle = i_cas_n ? vrts_pkg::CMD_REFRESH_RAS :
                vrts_pkg::CMD_REFRESH_CBR;
    else if (!i_we_n && i_special_function_select)
      o_cycle = vrts_pkg::CMD_ALT_WRITE;
    else if (!i_we_n)
      o_cycle = i_shift_port_gate_n ? vrts_pkg::CMD_PSEUDO :
                vrts_pkg::CMD_WRITE_XFER;
    else
      o_cycle = i_special_function_select ? vrts_pkg::CMD_SPLIT_XFER :
                vrts_pkg::CMD_READ_XFER;
  end

  // Address and strobe move on one host edge, so read the settled address
  always @(negedge i_cas_n) #1 col_q = i_addr[7:0];

  // Data moves at row strobe rise, once the column tap is known
  always @(posedge i_ras_n) begin
    if (xfer_q && o_cycle == vrts_pkg::CMD_SPLIT_XFER) begin
      // Only the inactive half, so the running half keeps streaming
      for (int c = 0; c < 256; c++)
        if (c[7] != pos_q[7]) shift_register_array[c] = mem[row_q][c];
      tap_q = col_q;
      split_q = 1;
    end else if (xfer_q) begin
      pos_q = col_q;
      shown_q = 0;
      rd_q = o_cycle == vrts_pkg::CMD_READ_XFER;
      wr_q = !rd_q;
      for (int c = 0; c < 256; c++)
        if (rd_q) shift_register_array[c] = mem[row_q][c];
        else if (o_cycle != vrts_pkg::CMD_PSEUDO)
          mem[row_q][c] = shift_register_array[c];
    end
  end

  always @(posedge i_shift_clock) begin
    if (!i_shift_port_gate_n && (rd_q || wr_q)) begin
      if (wr_q) shift_register_array[pos_q] = i_sdq;
      else begin
        data_q <= #5 shift_register_array[pos_q];
        shown_q <= #5 1'b1;
      end
      if (split_q && (pos_q == 8'h7f || pos_q == 8'hff)) begin
        pos_q = tap_q;
        split_q = 0;
      end else
        pos_q = pos_q + 8'h01;
    end
  end

  // Released pins show the inverse of the last word, never a stale copy
  assign o_drive = rd_q && shown_q && !i_shift_port_gate_n;
  assign o_sdq = o_drive ? data_q : ~data_q;
  assign o_half_activity_flag = pos_q[7];

  always @(o_drive or i_host_oe_n)
    if (o_drive && !i_host_oe_n) o_conflict = 1;
endmodule
